// >>> include/rcb_pkg.sv
`default_nettype none
package rcb_pkg;
    // ----------------------------------------
    // register indices on the serial port
    // ----------------------------------------
    localparam logic [7:0] BUCK_OUTPUT_CONFIG_ADDR = 8'h07;
    localparam logic [7:0] LINEAR_REGULATOR_CONFIG_ADDR = 8'h08;
    localparam logic [7:0] CONVERTER_MODE_STATUS_ADDR = 8'h09;
    localparam logic [7:0] KEEP_ON_BUTTON_MONITOR_CONTROL_ADDR = 8'h0A;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int KEEP_ALIVE_BIT = 7;
    localparam int DISCHARGE_BIT = 6;
    localparam int CODE_MSB = 5;
    localparam int FORCED_PWM_BIT = 7;
    localparam int BUCK_NIR_BIT = 6;
    localparam int LINREG_NIR_BIT = 5;
    localparam int KEEP_ON_BIT = 5;
    localparam int BUTTON_BIT = 4;
    localparam int MON_SELECT_BIT = 2;
    localparam int MON_ENABLE_BIT = 1;
    localparam int RESET_DELAY_BIT = 0;

    // ----------------------------------------
    // reset values (default variant)
    // ----------------------------------------
    localparam logic [7:0] BUCK_CONFIG_RESET = 8'h29;
    localparam logic [7:0] LINREG_CONFIG_RESET = 8'h65;
    localparam logic FORCED_PWM_RESET = 1'b0;
    localparam logic KEEP_ON_RESET = 1'b0;
    localparam logic MON_SELECT_RESET = 1'b1;
    localparam logic MON_ENABLE_RESET = 1'b0;
    localparam logic RESET_DELAY_RESET = 1'b1;

    // ----------------------------------------
    // voltage table, in millivolts
    // ----------------------------------------
    localparam logic [11:0] VOLT_BASE_MV = 12'd800;
    localparam logic [11:0] VOLT_FINE_STEP_MV = 12'd25;
    localparam logic [11:0] VOLT_MID_BASE_MV = 12'd1600;
    localparam logic [11:0] VOLT_MID_STEP_MV = 12'd50;
    localparam logic [11:0] VOLT_TOP_BASE_MV = 12'd3100;
    localparam logic [11:0] VOLT_TOP_STEP_MV = 12'd100;
    localparam logic [5:0] CODE_MID_FIRST = 6'd32;
    localparam logic [5:0] CODE_TOP_FIRST = 6'd61;

    // ----------------------------------------
    // reset-release delay
    // ----------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int DELAY_SHORT_MS = 11;
    localparam int DELAY_LONG_MS = 90;
    localparam int DELAY_SHORT_CYCLES = DELAY_SHORT_MS * (CLK_HZ / 1000);
    localparam int DELAY_LONG_CYCLES = DELAY_LONG_MS * (CLK_HZ / 1000);
    localparam int DELAY_CNT_W = 21;

    // bus access carrier
    typedef struct packed {
        logic wrEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } rcb_access_s;

    // regulator output controls
    typedef struct packed {
        logic enable;
        logic discharge;
        logic [11:0] voltageMv;
    } rcb_reg_out_s;
endpackage
`default_nettype wire

// >>> rtl/rcb_regulator_bank.sv
`timescale 1ns/1ps
`default_nettype none
module rcb_regulator_bank
    import rcb_pkg::*;
#(
    parameter int SHORT_DELAY_CYCLES = DELAY_SHORT_CYCLES, // shortened in sim
    parameter int LONG_DELAY_CYCLES = DELAY_LONG_CYCLES,
    parameter bit BUCK_EXT_DIVIDER = 1'b1,   // buck set by resistor divider
    parameter bit LINREG_EXT_DIVIDER = 1'b0, // linreg set by resistor divider
    parameter logic [11:0] BUCK_DIVIDER_MV = 12'd1800, // fixed divider level
    parameter logic [11:0] LINREG_DIVIDER_MV = 12'd3300
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // lockout from the supply monitor
    input wire logic undervoltageLockout,
    // register access from the serial port
    input wire rcb_access_s access,
    input wire logic rdEn,
    output logic [7:0] rdData,
    // pins and analogue status
    input wire logic holdPin,
    input wire logic buttonInputPinN,
    input wire logic buttonDebounced,
    input wire logic buckInRange,
    input wire logic linregInRange,
    input wire logic chargerInputGood,
    input wire logic resetRequest,
    // regulator controls
    output rcb_reg_out_s buckOut,
    output rcb_reg_out_s linregOut,
    output logic buckForcedPwm,
    output logic monitorAmpOn,
    output logic monitorSourceSelect,
    output logic resetReleased
);

    // ----------------------------------------
    // configuration state
    // ----------------------------------------
    logic [7:0] buckConfig, next_buckConfig;     // keep-alive, discharge, code
    logic [7:0] linregConfig, next_linregConfig; // same layout
    logic forcedPwm, next_forcedPwm;             // converter mode
    logic keepOn, next_keepOn;                   // software keep-on
    logic monSelect, next_monSelect;             // monitor source
    logic monEnable, next_monEnable;             // monitor enable
    logic resetDelaySel, next_resetDelaySel;     // delay choice

    // code to millivolts, one table for both outputs
    // fine, mid and top segment decode
    function automatic logic [11:0] code_to_mv(input logic [5:0] code);
        logic [11:0] c;
        c = {6'h00, code};
        if (code < CODE_MID_FIRST) begin
            code_to_mv = 12'(VOLT_BASE_MV + c * VOLT_FINE_STEP_MV);
        end else if (code < CODE_TOP_FIRST) begin
            code_to_mv = 12'(VOLT_MID_BASE_MV + (c - 12'(CODE_MID_FIRST)) * VOLT_MID_STEP_MV);
        end else begin
            code_to_mv = 12'(VOLT_TOP_BASE_MV + (c - 12'(CODE_TOP_FIRST)) * VOLT_TOP_STEP_MV);
        end
    endfunction

    // write decode
    always_comb begin
        next_buckConfig = buckConfig;
        next_linregConfig = linregConfig;
        next_forcedPwm = forcedPwm;
        next_keepOn = keepOn;
        next_monSelect = monSelect;
        next_monEnable = monEnable;
        next_resetDelaySel = resetDelaySel;
        if (access.wrEn) begin
            case (access.addr)
                BUCK_OUTPUT_CONFIG_ADDR: begin
                    next_buckConfig = access.wrData;
                end
                LINEAR_REGULATOR_CONFIG_ADDR: begin
                    next_linregConfig = access.wrData;
                end
                CONVERTER_MODE_STATUS_ADDR: begin
                    next_forcedPwm = access.wrData[FORCED_PWM_BIT];
                end
                KEEP_ON_BUTTON_MONITOR_CONTROL_ADDR: begin
                    next_keepOn = access.wrData[KEEP_ON_BIT];
                    next_monSelect = access.wrData[MON_SELECT_BIT];
                    next_monEnable = access.wrData[MON_ENABLE_BIT];
                    next_resetDelaySel = access.wrData[RESET_DELAY_BIT];
                end
                default: begin
                    // other addresses belong elsewhere
                end
            endcase
        end
    end

    // registers; lockout acts as a synchronous reload
    // reload defaults
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            buckConfig <= BUCK_CONFIG_RESET;
            linregConfig <= LINREG_CONFIG_RESET;
            forcedPwm <= FORCED_PWM_RESET;
            keepOn <= KEEP_ON_RESET;
            monSelect <= MON_SELECT_RESET;
            monEnable <= MON_ENABLE_RESET;
            resetDelaySel <= RESET_DELAY_RESET;
        end else if (undervoltageLockout) begin
            buckConfig <= BUCK_CONFIG_RESET;
            linregConfig <= LINREG_CONFIG_RESET;
            forcedPwm <= FORCED_PWM_RESET;
            keepOn <= KEEP_ON_RESET;
            monSelect <= MON_SELECT_RESET;
            monEnable <= MON_ENABLE_RESET;
            resetDelaySel <= RESET_DELAY_RESET;
        end else begin
            buckConfig <= next_buckConfig;
            linregConfig <= next_linregConfig;
            forcedPwm <= next_forcedPwm;
            keepOn <= next_keepOn;
            monSelect <= next_monSelect;
            monEnable <= next_monEnable;
            resetDelaySel <= next_resetDelaySel;
        end
    end

    // ----------------------------------------
    // enable logic
    // ----------------------------------------
    logic supplyRequest; // hold pin or button or keep-on
    logic next_buckEn, next_linregEn;
    logic [11:0] next_buckMv, next_linregMv;

    always_comb begin
        supplyRequest = keepOn | ~buttonInputPinN | holdPin;
        next_buckEn = supplyRequest | buckConfig[KEEP_ALIVE_BIT];
        next_linregEn = supplyRequest | linregConfig[KEEP_ALIVE_BIT];
        next_buckMv = BUCK_EXT_DIVIDER ? BUCK_DIVIDER_MV : code_to_mv(buckConfig[CODE_MSB:0]);
        next_linregMv = LINREG_EXT_DIVIDER ? LINREG_DIVIDER_MV : code_to_mv(linregConfig[CODE_MSB:0]);
    end

    // registered regulator controls
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            buckOut <= '0;
            linregOut <= '0;
            buckForcedPwm <= 1'b0;
            monitorAmpOn <= 1'b0;
            monitorSourceSelect <= 1'b0;
        end else begin
            buckOut.enable <= next_buckEn;
            buckOut.discharge <= ~next_buckEn & buckConfig[DISCHARGE_BIT];
            buckOut.voltageMv <= next_buckMv;
            linregOut.enable <= next_linregEn;
            linregOut.discharge <= ~next_linregEn & linregConfig[DISCHARGE_BIT];
            linregOut.voltageMv <= next_linregMv;
            buckForcedPwm <= forcedPwm;
            monitorAmpOn <= monEnable | chargerInputGood;
            monitorSourceSelect <= monSelect;
        end
    end

    // ----------------------------------------
    // reset-release delay counter
    // ----------------------------------------
    logic [DELAY_CNT_W-1:0] delayCnt, next_delayCnt;
    logic next_released;
    logic [DELAY_CNT_W-1:0] delayTarget;

    // counting restarts on every reset request
    always_comb begin
        delayTarget = resetDelaySel ? DELAY_CNT_W'(LONG_DELAY_CYCLES - 1)
                                    : DELAY_CNT_W'(SHORT_DELAY_CYCLES - 1);
        next_delayCnt = delayCnt;
        next_released = resetReleased;
        if (resetRequest || undervoltageLockout) begin
            next_delayCnt = '0;
            next_released = 1'b0;
        end else if (!resetReleased) begin
            if (delayCnt >= delayTarget) begin
                next_released = 1'b1;
            end else begin
                next_delayCnt = DELAY_CNT_W'(delayCnt + 1'b1);
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            delayCnt <= '0;
            resetReleased <= 1'b0;
        end else begin
            delayCnt <= next_delayCnt;
            resetReleased <= next_released;
        end
    end

    // ----------------------------------------
    // read-back
    // ----------------------------------------
    logic [7:0] next_rdData;

    // live status sampled at read time
    always_comb begin
        next_rdData = rdData;
        if (rdEn) begin
            next_rdData = 8'h00;
            case (access.addr)
                BUCK_OUTPUT_CONFIG_ADDR: begin
                    next_rdData = buckConfig;
                end
                LINEAR_REGULATOR_CONFIG_ADDR: begin
                    next_rdData = linregConfig;
                end
                CONVERTER_MODE_STATUS_ADDR: begin
                    next_rdData[FORCED_PWM_BIT] = forcedPwm;
                    next_rdData[BUCK_NIR_BIT] = ~(buckInRange & buckOut.enable);
                    next_rdData[LINREG_NIR_BIT] = ~(linregInRange & linregOut.enable);
                end
                KEEP_ON_BUTTON_MONITOR_CONTROL_ADDR: begin
                    next_rdData[KEEP_ON_BIT] = keepOn;
                    next_rdData[BUTTON_BIT] = buttonDebounced;
                    next_rdData[MON_SELECT_BIT] = monSelect;
                    next_rdData[MON_ENABLE_BIT] = monEnable;
                    next_rdData[RESET_DELAY_BIT] = resetDelaySel;
                end
                default: begin
                    next_rdData = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdData <= 8'h00;
        end else begin
            rdData <= next_rdData;
        end
    end

endmodule
`default_nettype wire

// >>> test/rcb_regulator_bank_props.sv
`timescale 1ns/1ps
`default_nettype none
module rcb_regulator_bank_props
    import rcb_pkg::*;
#(
    parameter int LONG_DELAY_CYCLES = 40,
    parameter logic [11:0] BUCK_DIVIDER_MV = 12'd1800
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // host side
    input wire logic undervoltageLockout,
    input wire rcb_access_s access,
    input wire logic rdEn,
    input wire logic [7:0] rdData,
    // pins
    input wire logic holdPin,
    input wire logic buttonInputPinN,
    input wire logic chargerInputGood,
    input wire logic resetRequest,
    // controls
    input wire rcb_reg_out_s buckOut,
    input wire rcb_reg_out_s linregOut,
    input wire logic buckForcedPwm,
    input wire logic monitorAmpOn,
    input wire logic resetReleased
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // ----------------------------------------
    // release wait counter
    // ----------------------------------------
    logic [7:0] waitCnt; // cycles held in reset
    logic [7:0] next_waitCnt;
    // any restart cause clears it; wraps only after the bound fired
    always_comb begin
        next_waitCnt = waitCnt + 8'h01;
        if (resetReleased || resetRequest || undervoltageLockout) begin
            next_waitCnt = 8'h00;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            waitCnt <= 8'h00;
        end else begin
            waitCnt <= next_waitCnt;
        end
    end
    AST_BUCK_DISCH: assert property (buckOut.discharge |-> !buckOut.enable)
        else $error("buck discharged while on");
    AST_LIN_DISCH: assert property (linregOut.discharge |-> !linregOut.enable)
        else $error("linreg discharged while on");
    AST_BUCK_FIXED: assert property ($past(rstn) |-> buckOut.voltageMv == BUCK_DIVIDER_MV)
        else $error("buck level follows code");
    AST_LIN_RANGE: assert property ($past(rstn) |-> linregOut.voltageMv inside {[12'd800:12'd3300]})
        else $error("linreg level off table");
    AST_HOLD_ON: assert property (holdPin [*3] |-> buckOut.enable && linregOut.enable)
        else $error("hold pin high but off");
    AST_BUTTON_ON: assert property (!buttonInputPinN [*3] |-> buckOut.enable && linregOut.enable)
        else $error("button pressed but off");
    AST_MON_AUTO: assert property (chargerInputGood [*3] |-> monitorAmpOn)
        else $error("monitor off with charger good");
    AST_PWM_WRITE: assert property (access.wrEn && access.addr == CONVERTER_MODE_STATUS_ADDR
        && !undervoltageLockout |-> ##3 buckForcedPwm == $past(access.wrData[7], 3))
        else $error("forced mode not taken");
    AST_UNMAPPED: assert property (rdEn && access.addr > 8'h0A |-> ##2 rdData == 8'h00)
        else $error("unmapped read not zero");
    AST_RESTART: assert property (resetRequest |-> ##2 !resetReleased)
        else $error("release not restarted");
    AST_RELEASE_BOUND: assert property (waitCnt <= 8'(LONG_DELAY_CYCLES + 4))
        else $error("release too late");
endmodule
bind rcb_regulator_bank rcb_regulator_bank_props #(
    .LONG_DELAY_CYCLES(LONG_DELAY_CYCLES),
    .BUCK_DIVIDER_MV(BUCK_DIVIDER_MV)
) rcb_regulator_bank_props_inst (
    .clk(clk), .rstn(rstn), .undervoltageLockout(undervoltageLockout),
    .access(access), .rdEn(rdEn), .rdData(rdData), .holdPin(holdPin),
    .buttonInputPinN(buttonInputPinN), .chargerInputGood(chargerInputGood),
    .resetRequest(resetRequest), .buckOut(buckOut), .linregOut(linregOut),
    .buckForcedPwm(buckForcedPwm), .monitorAmpOn(monitorAmpOn), .resetReleased(resetReleased)
);
`default_nettype wire

// >>> test/rcb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rcb_host_model
    import rcb_pkg::*;
(
    // clock
    input wire logic clk,
    // register access
    output var rcb_access_s access,
    output var logic rdEn,
    input wire logic [7:0] rdData
);
    logic [5:0] lastBuck; // buck code last sent
    initial begin
        access = '0;
        rdEn = 1'b0;
        lastBuck = 6'h29;
    end
    // write; the byte really sent is handed back
    task automatic wr(input logic [7:0] a, inout logic [7:0] d);
        if (a == BUCK_OUTPUT_CONFIG_ADDR) begin
            if (int'(d[5:0]) * 100 > int'(lastBuck) * 108) begin
                d[5:0] = lastBuck;
            end
            lastBuck = d[5:0];
        end
        @(negedge clk);
        access = '{wrEn: 1'b1, addr: a, wrData: d};
        @(negedge clk);
        access.wrEn = 1'b0;
        @(negedge clk);
    endtask
    // read; data sampled a cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        access.addr = a;
        rdEn = 1'b1;
        @(negedge clk);
        rdEn = 1'b0;
        @(negedge clk);
        d = rdData;
    endtask
endmodule
`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
    import rcb_pkg::*;
;
    localparam logic [11:0] BUCK_MV = 12'd1800;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic undervoltageLockout, holdPin, buttonN, buttonDb, buckIn, linIn, chg, rstReq;
    rcb_access_s access;
    logic rdEn;
    logic [7:0] rdData;
    rcb_reg_out_s buckOut, linregOut;
    logic forcedPwm, ampOn, srcSel, released;
    int failures = 0;
    int checked = 0;
    int n;
    logic [31:0] rnd = 32'd98079;
    logic [7:0] mdl [0:3]; // register model
    logic [7:0] mk [0:3] = '{8'hFF, 8'hFF, 8'h80, 8'h27}; // writable bits
    logic [7:0] d;
    always #25 clk = ~clk;
    rcb_regulator_bank #(
        .SHORT_DELAY_CYCLES(10),
        .LONG_DELAY_CYCLES(40),
        .BUCK_DIVIDER_MV(BUCK_MV)
    ) rcb_regulator_bank_inst (
        .clk(clk), .rstn(rstn), .undervoltageLockout(undervoltageLockout),
        .access(access), .rdEn(rdEn), .rdData(rdData), .holdPin(holdPin),
        .buttonInputPinN(buttonN), .buttonDebounced(buttonDb), .buckInRange(buckIn),
        .linregInRange(linIn), .chargerInputGood(chg), .resetRequest(rstReq),
        .buckOut(buckOut), .linregOut(linregOut), .buckForcedPwm(forcedPwm),
        .monitorAmpOn(ampOn), .monitorSourceSelect(srcSel), .resetReleased(released)
    );
    rcb_host_model host (.clk(clk), .access(access), .rdEn(rdEn), .rdData(rdData));
    function automatic logic [31:0] nx(input logic [31:0] s);
        for (int i = 0; i < 8; i++) begin
            s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
        end
        return s;
    endfunction
    // code to millivolts
    function automatic int mv(input int c);
        if (c < 32) return 800 + 25 * c;
        if (c < 61) return 1600 + 50 * (c - 32);
        return 3100 + 100 * (c - 61);
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // compare all controls but released, and all readbacks, to the model
    task automatic verify();
        logic enB, enL;
        logic [7:0] r;
        logic [7:0] x [0:4];
        enB = holdPin | mdl[3][5] | !buttonN | mdl[0][7];
        enL = holdPin | mdl[3][5] | !buttonN | mdl[1][7];
        chk("buck", buckOut, {enB, mdl[0][6] & !enB, BUCK_MV});
        chk("linreg", linregOut, {enL, mdl[1][6] & !enL, 12'(mv(mdl[1][5:0]))});
        chk("mode", {forcedPwm, ampOn, srcSel}, {mdl[2][7], mdl[3][1] | chg, mdl[3][2]});
        x = '{mdl[0], mdl[1], {mdl[2][7], !(buckIn & enB), !(linIn & enL), 5'h00},
            mdl[3] | {3'b000, buttonDb, 4'h0}, 8'h00};
        for (int a = 7; a < 12; a++) begin
            host.rd(8'(a), r);
            chk("read", r, x[a - 7]);
        end
    endtask
    initial begin
        {undervoltageLockout, holdPin, buttonDb, buckIn, linIn, chg, rstReq} = '0;
        buttonN = 1'b1;
        mdl = '{8'h29, 8'h65, 8'h00, 8'h05};
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        // outputs are registered: let two edges load the defaults first
        repeat (2) @(negedge clk);
        verify();
        // walk every linreg code with random neighbours
        for (int i = 0; i < 64; i++) begin
            for (int a = 0; a < 5; a++) begin
                rnd = nx(rnd);
                d = (a == 1) ? {rnd[7:6], 6'(i)} : rnd[7:0];
                host.wr(8'(a + 7), d);
                if (a < 4) mdl[a] = d & mk[a];
            end
            {holdPin, buttonN, buttonDb, buckIn, linIn, chg} = rnd[13:8];
            repeat (3) @(negedge clk);
            verify();
        end
        // lockout reloads defaults and drops writes
        undervoltageLockout = 1'b1;
        d = 8'hC0;
        host.wr(BUCK_OUTPUT_CONFIG_ADDR, d);
        undervoltageLockout = 1'b0;
        host.lastBuck = 6'h29;
        mdl = '{8'h29, 8'h65, 8'h00, 8'h05};
        repeat (3) @(negedge clk);
        verify();
        // short then long release delay
        for (int b = 0; b < 2; b++) begin
            d = 8'(b);
            host.wr(KEEP_ON_BUTTON_MONITOR_CONTROL_ADDR, d);
            mdl[3] = d;
            rstReq = 1'b1;
            @(negedge clk);
            rstReq = 1'b0;
            for (n = 0; n < 100 && released !== 1'b1; n++) @(negedge clk);
            chk("delay", n >= (b ? 38 : 8) && n <= (b ? 43 : 13), 1);
        end
        verify();
        conclude();
    end
endmodule
`default_nettype wire
